/* File: design/ffo_datapath.v */
// Behaviour
// - Top bit of 24-bit fixed word is sign; one means one's-complement negative.
// - Fixed-point binary point sits right of bit 00; operands are integers.
// - Float coefficient is a normalised 36-bit fraction in the low bits.
// - Bit 47 is the coefficient sign; negative fractions are one's complement.
// - Exponent is an 11-bit biased field spanning 0000 to 3777 octal.
// - Bias is 2000 for positive, 1777 for negative true exponents.
// - Exponent sits in bits 46..36, coefficient from bit 35 down.
// - Floats compare correctly through the plain fixed-point comparison.
// - Float ops use paired accumulators as one 48-bit register, operand at M, M+1.
// - Upper accumulator and M carry bits 47..24; lower and M+1 carry 23..00.
// - Alignment shifts at most 64; beyond 36 the larger operand is returned.
// - Float operand address supports indexing and indirect addressing.
// - Double multiply and divide trap when the arithmetic option is absent.
// - Either zero accepted as operand; zero results are positive zero, except that a load copies the word as stored.
`include "ffo_regs.vh"

module ffo_datapath (
	input wire clk_sys,
	input wire reset_n,
	input wire start,
	input wire [2:0] op_code,
	input wire [14:0] addr_field,
	input wire [1:0] index_sel,
	input wire indirect,
	input wire [14:0] index_reg1,
	input wire [14:0] index_reg2,
	input wire [14:0] index_reg3,
	input wire [23:0] acc_upper_in,
	input wire [23:0] acc_lower_in,
	input wire arith_option,
	output reg mem_req,
	output reg [14:0] mem_addr,
	input wire [23:0] mem_rdata,
	input wire mem_ack,
	output reg [23:0] acc_upper,
	output reg [23:0] acc_lower,
	output reg [47:0] ext_reg,
	output reg busy,
	output reg done,
	output reg trap,
	output reg cmp_gt,
	output reg cmp_eq,
	output reg arith_fault
);

localparam ST_IDLE = 3'h0;
localparam ST_IND = 3'h1;
localparam ST_RD1 = 3'h2;
localparam ST_RD2 = 3'h3;
localparam ST_EXEC = 3'h4;

// ====================================================================
// Helper functions
function signed [12:0] ffo_unbias;
	input [10:0] e;
	begin
		// Biased 1777 is the unused minus-zero code and reads as zero
		if (e >= `FFO_BIAS_POS)
			ffo_unbias = $signed({2'b00, e}) - $signed({2'b00, `FFO_BIAS_POS});
		else
			ffo_unbias = $signed({2'b00, e}) - $signed({2'b00, `FFO_BIAS_NEG});
	end
endfunction

function [10:0] ffo_bias;
	input signed [12:0] t;
	reg [12:0] s;
	begin
		// Minus zero never arises here, so zero takes the positive bias
		if (t[12])
			s = t + {2'b00, `FFO_BIAS_NEG};
		else
			s = t + {2'b00, `FFO_BIAS_POS};
		ffo_bias = s[10:0];
	end
endfunction

function [46:0] ffo_mag47;
	input [47:0] w;
	begin
		ffo_mag47 = w[`FFO_SIGN_BIT] ? ~w[46:0] : w[46:0];
	end
endfunction

function [47:0] ffo_sign48;
	input sgn;
	input [46:0] mag;
	begin
		if (mag == 47'h0)
			ffo_sign48 = `FFO_RST_WORD;
		else if (sgn)
			ffo_sign48 = ~{1'b0, mag};
		else
			ffo_sign48 = {1'b0, mag};
	end
endfunction

function signed [48:0] ffo_val48;
	input [47:0] w;
	begin
		// Both zeros map to the value zero
		if (w[`FFO_SIGN_BIT])
			ffo_val48 = -$signed({2'b00, ~w[46:0]});
		else
			ffo_val48 = $signed({2'b00, w[46:0]});
	end
endfunction

function [5:0] ffo_lead;
	input [35:0] m;
	integer i;
	reg found;
	begin
		ffo_lead = 6'h00;
		found = 1'b0;
		for (i = 35; i >= 0; i = i - 1)
		begin
			if (!found && m[i])
			begin
				found = 1'b1;
				ffo_lead = 6'h23 - i[5:0];
			end
		end
	end
endfunction

// ====================================================================
// State
reg [2:0] state;
reg [2:0] op_q;
reg [47:0] paired_accumulators;
reg [47:0] opnd;

// ====================================================================
// Address formation
reg [14:0] index_val;
wire [14:0] indexed_addr;
wire [14:0] eff_addr;

always @*
begin
	case (index_sel)
		2'h1: index_val = index_reg1;
		2'h2: index_val = index_reg2;
		2'h3: index_val = index_reg3;
		default: index_val = `FFO_RST_ADDR;
	endcase
end

ffo_oc_adder #(
	.WIDTH(15),
	.NORM_ZERO(0)
) u_addr_add (
	.a(addr_field),
	.b(index_val),
	.sub(1'b0),
	.sum(indexed_addr)
);

// Without an index the field passes untouched, keeping 77777 intact
assign eff_addr = (index_sel == 2'h0) ? addr_field : indexed_addr;

// ====================================================================
// Fixed-point adders
wire [23:0] fix_sum;
wire [47:0] dp_sum;

ffo_oc_adder #(
	.WIDTH(24),
	.NORM_ZERO(1)
) u_fix_add (
	.a(paired_accumulators[47:24]),
	.b(opnd[47:24]),
	.sub(1'b0),
	.sum(fix_sum)
);

ffo_oc_adder #(
	.WIDTH(48),
	.NORM_ZERO(1)
) u_dp_add (
	.a(paired_accumulators),
	.b(opnd),
	.sub(1'b0),
	.sum(dp_sum)
);

// ====================================================================
// Execution datapath
reg [47:0] next_res;
reg [47:0] next_ext;
reg next_write;
reg next_gt;
reg next_eq;
reg next_fault;
reg [47:0] wa;
reg [47:0] wb;
reg [46:0] ua;
reg [46:0] ub;
reg signed [12:0] ea;
reg signed [12:0] eb;
reg signed [12:0] diff;
reg [12:0] adiff;
reg [6:0] shift;
reg a_big;
reg sgn_big;
reg sgn_small;
reg sgn_res;
reg [35:0] m_big;
reg [35:0] m_small;
reg [36:0] msum;
reg [35:0] mnorm;
reg signed [12:0] eres;
reg [5:0] lz;
reg signed [48:0] va;
reg signed [48:0] vb;
reg [46:0] mag_a;
reg [46:0] mag_b;
reg [93:0] prod;

always @*
begin
	next_res = paired_accumulators;
	next_ext = ext_reg;
	next_write = 1'b1;
	next_gt = cmp_gt;
	next_eq = cmp_eq;
	next_fault = 1'b0;
	wa = paired_accumulators;
	wb = (op_q == `FFO_OP_FLT_SUB) ? ~opnd : opnd;
	ua = ffo_mag47(wa);
	ub = ffo_mag47(wb);
	ea = ffo_unbias(ua[`FFO_EXP_HI:`FFO_EXP_LO]);
	eb = ffo_unbias(ub[`FFO_EXP_HI:`FFO_EXP_LO]);
	diff = ea - eb;
	a_big = !diff[12];
	adiff = diff[12] ? -diff : diff;
	shift = (adiff > {6'h00, `FFO_MAX_SHIFT}) ? `FFO_MAX_SHIFT : adiff[6:0];
	sgn_big = a_big ? wa[`FFO_SIGN_BIT] : wb[`FFO_SIGN_BIT];
	sgn_small = a_big ? wb[`FFO_SIGN_BIT] : wa[`FFO_SIGN_BIT];
	m_big = a_big ? ua[`FFO_COEF_HI:0] : ub[`FFO_COEF_HI:0];
	m_small = (a_big ? ub[`FFO_COEF_HI:0] : ua[`FFO_COEF_HI:0]) >> shift;
	eres = a_big ? ea : eb;
	sgn_res = sgn_big;
	if (sgn_big == sgn_small)
		msum = {1'b0, m_big} + {1'b0, m_small};
	else if (m_big >= m_small)
		msum = {1'b0, m_big} - {1'b0, m_small};
	else
	begin
		msum = {1'b0, m_small} - {1'b0, m_big};
		sgn_res = sgn_small;
	end
	lz = ffo_lead(msum[35:0]);
	mnorm = msum[35:0];
	va = ffo_val48(paired_accumulators);
	vb = ffo_val48(opnd);
	mag_a = ffo_mag47(paired_accumulators);
	mag_b = ffo_mag47(opnd);
	prod = mag_a * mag_b;
	case (op_q)
		`FFO_OP_FIX_ADD:
			next_res = {fix_sum, paired_accumulators[23:0]};
		`FFO_OP_DP_ADD:
			next_res = dp_sum;
		`FFO_OP_FLT_ADD, `FFO_OP_FLT_SUB:
		begin
			if (adiff > `FFO_COEF_SPAN)
				// The smaller coefficient would shift out entirely
				// Passing through the sign helper turns a minus-zero operand into plus zero
				next_res = a_big ? ffo_sign48(wa[47], ua) : ffo_sign48(wb[47], ub);
			else
			begin
				if (msum[36])
				begin
					mnorm = msum[36:1];
					eres = eres + 13'sh0001;
				end
				else
				begin
					mnorm = msum[35:0] << lz;
					eres = eres - $signed({7'h00, lz});
				end
				if (msum == 37'h0)
					next_res = `FFO_RST_WORD;
				else if (eres > $signed(`FFO_TRUE_MAX) || eres < -$signed(`FFO_TRUE_MAX))
				begin
					next_fault = 1'b1;
					next_write = 1'b0;
				end
				else
					next_res = ffo_sign48(sgn_res, {ffo_bias(eres), mnorm});
			end
		end
		`FFO_OP_FLT_CMP:
		begin
			// Biased exponents make the plain signed compare order floats
			next_write = 1'b0;
			next_gt = (va > vb);
			next_eq = (va == vb);
		end
		`FFO_OP_DP_MUL:
		begin
			next_res = ffo_sign48(paired_accumulators[47] ^ opnd[47], prod[46:0]);
			next_ext = {1'b0, prod[93:47]};
		end
		`FFO_OP_DP_DIV:
		begin
			if (mag_b == 47'h0)
			begin
				next_fault = 1'b1;
				next_write = 1'b0;
			end
			else
			begin
				next_res = ffo_sign48(paired_accumulators[47] ^ opnd[47], mag_a / mag_b);
				next_ext = ffo_sign48(paired_accumulators[47], mag_a % mag_b);
			end
		end
		`FFO_OP_FLT_LOAD:
			next_res = opnd;
		default:
			next_write = 1'b0;
	endcase
end

// ====================================================================
// Sequencer
always @(posedge clk_sys or negedge reset_n)
begin
	if (!reset_n)
	begin
		state <= ST_IDLE;
		op_q <= `FFO_OP_FIX_ADD;
		paired_accumulators <= `FFO_RST_WORD;
		opnd <= `FFO_RST_WORD;
		mem_req <= 1'b0;
		mem_addr <= `FFO_RST_ADDR;
		acc_upper <= `FFO_RST_HALF;
		acc_lower <= `FFO_RST_HALF;
		ext_reg <= `FFO_RST_WORD;
		busy <= 1'b0;
		done <= 1'b0;
		trap <= 1'b0;
		cmp_gt <= 1'b0;
		cmp_eq <= 1'b0;
		arith_fault <= 1'b0;
	end
	else
	begin
		done <= 1'b0;
		trap <= 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (start)
				begin
					if ((op_code == `FFO_OP_DP_MUL || op_code == `FFO_OP_DP_DIV) && !arith_option)
						trap <= 1'b1;
					else
					begin
						op_q <= op_code;
						paired_accumulators <= {acc_upper_in, acc_lower_in};
						mem_req <= 1'b1;
						mem_addr <= eff_addr;
						busy <= 1'b1;
						state <= indirect ? ST_IND : ST_RD1;
					end
				end
			end
			ST_IND:
			begin
				if (mem_ack)
				begin
					mem_addr <= mem_rdata[14:0];
					state <= ST_RD1;
				end
			end
			ST_RD1:
			begin
				if (mem_ack)
				begin
					opnd[47:24] <= mem_rdata;
					if (op_q == `FFO_OP_FIX_ADD)
					begin
						mem_req <= 1'b0;
						state <= ST_EXEC;
					end
					else
					begin
						mem_addr <= mem_addr + 15'h0001;
						state <= ST_RD2;
					end
				end
			end
			ST_RD2:
			begin
				if (mem_ack)
				begin
					opnd[23:0] <= mem_rdata;
					mem_req <= 1'b0;
					state <= ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				if (next_write)
				begin
					acc_upper <= next_res[47:24];
					acc_lower <= next_res[23:0];
				end
				ext_reg <= next_ext;
				cmp_gt <= next_gt;
				cmp_eq <= next_eq;
				arith_fault <= next_fault;
				busy <= 1'b0;
				done <= 1'b1;
				state <= ST_IDLE;
			end
			default:
				state <= ST_IDLE;
		endcase
	end
end

endmodule // ffo_datapath

/* File: shared/ffo_regs.vh */
`ifndef FFO_REGS_VH
`define FFO_REGS_VH

// ====================================================================
// Word layout
`define FFO_WORD_W 48
`define FFO_HALF_W 24
`define FFO_ADDR_W 15
`define FFO_SIGN_BIT 47
`define FFO_EXP_HI 46
`define FFO_EXP_LO 36
`define FFO_COEF_HI 35
`define FFO_COEF_W 36
`define FFO_FIX_SIGN 23

// ====================================================================
// Exponent bias (octal 2000 and 1777) and true exponent limit (octal 1777)
`define FFO_BIAS_POS 11'h400
`define FFO_BIAS_NEG 11'h3FF
`define FFO_TRUE_MAX 13'h03FF

// ====================================================================
// Alignment limits
`define FFO_MAX_SHIFT 7'h40
`define FFO_COEF_SPAN 13'h0024

// ====================================================================
// Operation codes
`define FFO_OP_FIX_ADD 3'h0
`define FFO_OP_DP_ADD 3'h1
`define FFO_OP_FLT_ADD 3'h2
`define FFO_OP_FLT_SUB 3'h3
`define FFO_OP_FLT_CMP 3'h4
`define FFO_OP_DP_MUL 3'h5
`define FFO_OP_DP_DIV 3'h6
`define FFO_OP_FLT_LOAD 3'h7

// ====================================================================
// Reset values
`define FFO_RST_WORD 48'h000000000000
`define FFO_RST_HALF 24'h000000
`define FFO_RST_ADDR 15'h0000

`endif

/* File: design/ffo_oc_adder.v */
// ====================================================================
// One's-complement adder with end-around carry
module ffo_oc_adder #(
	parameter WIDTH = 24,
	parameter NORM_ZERO = 1
)(
	input wire [WIDTH-1:0] a,
	input wire [WIDTH-1:0] b,
	input wire sub,
	output reg [WIDTH-1:0] sum
);

reg [WIDTH-1:0] b_eff;
reg [WIDTH:0] raw;
reg [WIDTH-1:0] wrapped;

always @*
begin
	b_eff = sub ? ~b : b;
	raw = {1'b0, a} + {1'b0, b_eff};
	wrapped = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
	// Negative zero is never delivered as an arithmetic result
	if (NORM_ZERO != 0 && (&wrapped))
		sum = {WIDTH{1'b0}};
	else
		sum = wrapped;
end

endmodule // ffo_oc_adder

/* File: test/ffo_mem_model.sv */
// ==========
// Core storage behind the datapath
module ffo_mem_model (
	input wire clk_sys,
	input wire reset_n,
	input wire slow,
	input wire mem_req,
	input wire [14:0] mem_addr,
	output logic [23:0] mem_rdata,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] mem [0:15];
	logic [1:0] wait_cnt;
	// Data turns over each idle cycle so a sample one cycle late never matches
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 24'h000000;
			wait_cnt <= 2'h0;
		end
		else if (mem_req && !mem_ack && wait_cnt == 2'h0)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[3:0]];
			wait_cnt <= slow ? 2'h2 : 2'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_cnt != 2'h0)
				wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule // ffo_mem_model

/* File: test/ffo_datapath_checker.sv */
// ==========
// Port checks
module ffo_datapath_checker (
	input wire clk_sys,
	input wire reset_n,
	input wire start,
	input wire [2:0] op_code,
	input wire [14:0] addr_field,
	input wire [1:0] index_sel,
	input wire indirect,
	input wire arith_option,
	input wire mem_req,
	input wire [14:0] mem_addr,
	input wire mem_ack,
	input wire [23:0] acc_upper,
	input wire [23:0] acc_lower,
	input wire busy,
	input wire done,
	input wire trap,
	input wire cmp_gt,
	input wire cmp_eq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [2:0] op_q;
	logic wide;
	logic [1:0] acks;
	logic [14:0] ack_addr;
	wire take = start && !busy;
	wire dp_trap = take && (op_code == 3'h5 || op_code == 3'h6) && !arith_option;
	wire adds = op_q == 3'h1 || op_q == 3'h2 || op_q == 3'h3;
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_q <= 3'h0;
			wide <= 1'b0;
			acks <= 2'h0;
			ack_addr <= 15'h0000;
		end
		else if (take)
		begin
			op_q <= op_code;
			wide <= op_code != 3'h0 && !indirect;
			acks <= 2'h0;
		end
		else if (mem_req && mem_ack)
		begin
			acks <= acks + 2'h1;
			ack_addr <= mem_addr;
		end
	end
	property p_trap; dp_trap |=> trap && !mem_req && !done; endproperty
	a_trap: assert property (p_trap) else $error("no trap");
	property p_notrap; take && arith_option |=> !trap; endproperty
	a_notrap: assert property (p_notrap) else $error("bad trap");
	property p_addr; take && index_sel == 2'h0 && !indirect && !dp_trap |=> mem_req && mem_addr == $past(addr_field); endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_pair; wide && acks == 2'h1 && mem_req |-> mem_addr == ack_addr + 15'h0001; endproperty
	a_pair: assert property (p_pair) else $error("second word address");
	property p_fixzero; done && op_q == 3'h0 |-> acc_upper != 24'hFFFFFF; endproperty
	a_fixzero: assert property (p_fixzero) else $error("negative zero");
	property p_fltzero; done && adds |-> {acc_upper, acc_lower} != 48'hFFFFFFFFFFFF; endproperty
	a_fltzero: assert property (p_fltzero) else $error("negative zero");
	property p_cmp; done && op_q != 3'h4 |-> $stable(cmp_gt) && $stable(cmp_eq) && !(cmp_gt && cmp_eq); endproperty
	a_cmp: assert property (p_cmp) else $error("compare flags");
	property p_done; done |-> !busy ##1 !done; endproperty
	a_done: assert property (p_done) else $error("done width");
endmodule // ffo_datapath_checker
bind ffo_datapath ffo_datapath_checker ffo_datapath_checker_inst (.clk_sys, .reset_n, .start, .op_code,
	.addr_field, .index_sel, .indirect, .arith_option, .mem_req, .mem_addr, .mem_ack, .acc_upper,
	.acc_lower, .busy, .done, .trap, .cmp_gt, .cmp_eq);

/* File: test/ffo_datapath_tb.sv */
// ==========
// Bench
module ffo_datapath_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, start, indirect, arith_option, slow;
	logic [2:0] op_code;
	logic [14:0] addr_field, index_reg1, index_reg2, index_reg3;
	logic [1:0] index_sel;
	logic [23:0] acc_upper_in, acc_lower_in;
	wire mem_req, mem_ack, busy, done, trap, cmp_gt, cmp_eq, arith_fault;
	wire [14:0] mem_addr;
	wire [23:0] mem_rdata, acc_upper, acc_lower;
	wire [47:0] ext_reg;
	int fails = 0;
	int checks_done = 0;
	ffo_datapath ffo_datapath_inst (.clk_sys, .reset_n, .start, .op_code, .addr_field, .index_sel,
		.indirect, .index_reg1, .index_reg2, .index_reg3, .acc_upper_in, .acc_lower_in, .arith_option,
		.mem_req, .mem_addr, .mem_rdata, .mem_ack, .acc_upper, .acc_lower, .ext_reg, .busy, .done,
		.trap, .cmp_gt, .cmp_eq, .arith_fault);
	ffo_mem_model ffo_mem_model_inst (.clk_sys, .reset_n, .slow, .mem_req, .mem_addr, .mem_rdata, .mem_ack);
	task automatic test_done();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Completion is looked at on the falling edge, after the rising edge has settled
	task automatic run_op(input logic [2:0] op, input logic [14:0] addr, input logic [1:0] isel,
		input logic ind, input logic [47:0] acc);
		int n;
		@(posedge clk_sys);
		start <= 1'b1;
		op_code <= op;
		addr_field <= addr;
		index_sel <= isel;
		indirect <= ind;
		acc_upper_in <= acc[47:24];
		acc_lower_in <= acc[23:0];
		@(posedge clk_sys);
		start <= 1'b0;
		n = 0;
		@(negedge clk_sys);
		while (done !== 1'b1 && trap !== 1'b1 && n < 50)
		begin
			@(negedge clk_sys);
			n++;
		end
		// A lost completion counts against the run even if the later compare happens to match
		if (n >= 50)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, n, 50);
		end
	endtask
	task automatic t_fixed();
		run_op(3'h0, 15'h0003, 2'h0, 1'b0, 48'h000005000000);
		check({24'h0, acc_upper}, 48'h2);
		run_op(3'h0, 15'h0004, 2'h0, 1'b0, 48'h000005000000);
		check({24'h0, acc_upper}, 48'h0);
	endtask
	task automatic t_float();
		run_op(3'h2, 15'h0004, 2'h1, 1'b0, 48'h400800000000);
		check({acc_upper, acc_lower}, 48'h401800000000);
		run_op(3'h3, 15'h0004, 2'h1, 1'b0, 48'h400800000000);
		check({acc_upper, acc_lower}, 48'h0);
		run_op(3'h2, 15'h0009, 2'h0, 1'b1, 48'h403800000000);
		check({acc_upper, acc_lower}, 48'h403900000000);
		run_op(3'h2, 15'h000A, 2'h0, 1'b0, 48'h403800000000);
		check({acc_upper, acc_lower}, 48'h428800000000);
		run_op(3'h3, 15'h000A, 2'h0, 1'b0, 48'h403800000000);
		check({acc_upper, acc_lower}, 48'hBD77FFFFFFFF);
		// Load takes the storage pair unchanged, first word to the upper half
		run_op(3'h7, 15'h000A, 2'h0, 1'b0, 48'h000000000000);
		check({acc_upper, acc_lower}, 48'h428800000000);
	endtask
	task automatic t_cmp();
		run_op(3'h4, 15'h0006, 2'h0, 1'b0, 48'h403800000000);
		check({46'h0, cmp_gt, cmp_eq}, 48'h2);
		run_op(3'h4, 15'h0006, 2'h0, 1'b0, 48'hBC7FFFFFFFFF);
		check({46'h0, cmp_gt, cmp_eq}, 48'h0);
		run_op(3'h4, 15'h0006, 2'h0, 1'b0, 48'h400800000000);
		check({46'h0, cmp_gt, cmp_eq}, 48'h1);
	endtask
	task automatic t_dp();
		run_op(3'h1, 15'h000C, 2'h0, 1'b0, 48'h000000000003);
		check({acc_upper, acc_lower}, 48'h8);
		run_op(3'h5, 15'h000C, 2'h0, 1'b0, 48'h000000000003);
		check({acc_upper, acc_lower}, 48'hF);
		check(ext_reg, 48'h0);
		run_op(3'h6, 15'h000C, 2'h0, 1'b0, 48'h000000000011);
		check({acc_upper, acc_lower}, 48'h3);
		check(ext_reg, 48'h2);
		check({47'h0, arith_fault}, 48'h0);
		// Storage pair at 11 and 12 is zero, so the divide must fault and leave the result alone
		run_op(3'h6, 15'h000B, 2'h0, 1'b0, 48'h00000000000F);
		check({47'h0, arith_fault}, 48'h1);
		check({acc_upper, acc_lower}, 48'h3);
		@(posedge clk_sys);
		arith_option <= 1'b0;
		run_op(3'h5, 15'h000C, 2'h0, 1'b0, 48'h000000000003);
		check({47'h0, trap}, 48'h1);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#50000;
		fails++;
		test_done();
	end
	initial
	begin
		{reset_n, start, indirect, slow, op_code, addr_field, index_sel} = '0;
		{acc_upper_in, acc_lower_in, index_reg2, index_reg3} = '0;
		index_reg1 = 15'h0002;
		arith_option = 1'b1;
		ffo_mem_model_inst.mem[3] = 24'hFFFFFC;
		ffo_mem_model_inst.mem[4] = 24'hFFFFFA;
		ffo_mem_model_inst.mem[6] = 24'h400800;
		ffo_mem_model_inst.mem[7] = 24'h000000;
		ffo_mem_model_inst.mem[9] = 24'h000006;
		ffo_mem_model_inst.mem[10] = 24'h428800;
		ffo_mem_model_inst.mem[11] = 24'h000000;
		ffo_mem_model_inst.mem[12] = 24'h000000;
		ffo_mem_model_inst.mem[13] = 24'h000005;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_fixed();
		slow <= 1'b1;
		t_float();
		slow <= 1'b0;
		t_cmp();
		t_dp();
		test_done();
	end
endmodule // ffo_datapath_tb
